/* rtl/synth_serial_pkg.sv */
// Constants, field layout and state types of the synthesizer serial front end
package synth_serial_pkg;

	// ------------------------------------------------------------
	// Serial word layout
	// ------------------------------------------------------------
	localparam int WORD_BITS = 21;
	localparam int FUNC_BITS = 18;
	localparam int REF_BITS = 19;
	localparam int REF_DIV_BITS = 14;
	localparam int FB_BITS = 19;
	localparam int CNT_BITS = 5;

	// Control bits sit in the two least significant positions
	localparam int DEST_LO_POS = 0;
	localparam int DEST_HI_POS = 1;
	localparam int PAYLOAD_POS = 2;

	localparam logic [1:0] DEST_REF = 2'h0;
	localparam logic [1:0] DEST_FEEDBACK = 2'h1;
	localparam logic [1:0] DEST_FUNCTION = 2'h2;
	localparam logic [1:0] DEST_INIT = 2'h3;

	// Reference word: precision bit is its top bit
	localparam int LOCK_PRECISION_POS = 18;

	// Function word field positions (bit 0 is the first function bit)
	localparam int COUNTER_RESET_POS = 0;
	localparam int POWERDOWN_LO_POS = 1;
	localparam int OUT_SEL_POS = 2;
	localparam int OUT_SEL_BITS = 3;
	localparam int DETECTOR_POL_POS = 5;
	localparam int PUMP_HIZ_POS = 6;
	localparam int FAST_SETTLE_EN_POS = 7;
	localparam int FAST_SETTLE_CTRL_POS = 8;
	localparam int TIMEOUT_EN_POS = 9;
	localparam int TIMEOUT_COUNT_POS = 10;
	localparam int TEST_SELECT_POS = 14;
	localparam int POWERDOWN_HI_POS = 17;

	// Output function codes
	localparam logic [2:0] OUT_SEL_DIGITAL_LOCK = 3'h1;
	localparam logic [2:0] OUT_SEL_ANALOG_LOCK = 3'h5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [WORD_BITS-1:0] SHIFT_RESET = 21'h000000;
	localparam logic [FUNC_BITS-1:0] FUNC_RESET = 18'h00000;
	localparam logic [REF_BITS-1:0] REF_RESET = 19'h00000;
	localparam logic [FB_BITS-1:0] FB_RESET = 19'h00000;

	// ------------------------------------------------------------
	// Lock detection thresholds
	// ------------------------------------------------------------
	localparam int ERR_BITS = 8;
	localparam logic [ERR_BITS-1:0] LOCK_WINDOW_NS = 8'h0f;
	localparam logic [ERR_BITS-1:0] UNLOCK_LIMIT_NS = 8'h1e;
	localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
	localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;

	typedef enum logic [1:0] {
		LOCK_HUNT = 2'b01,
		LOCK_HELD = 2'b10
	} lock_state_type;

endpackage

/* rtl/pin_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinSync
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// First stage feeds only the second stage
	always_comb begin
		nxt_meta = pinIn;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign pinSync = sync_ff;

endmodule
`default_nettype wire

/* rtl/digital_lock_detect.sv */
// Digital lock detector counting quiet comparator cycles
`timescale 1ns/1ps
`default_nettype none
module digital_lock_detect
	import synth_serial_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic compareTick,
	input wire logic [ERR_BITS-1:0] phaseErrorNs,
	input wire logic lockPrecisionBit,
	output logic lockIndicator
);

	lock_state_type state_ff;
	lock_state_type nxt_state;
	logic [2:0] quiet_ff;
	logic [2:0] nxt_quiet;
	logic [2:0] needCycles;
	logic quietCycle;
	logic loudCycle;

	// ------------------------------------------------------------
	// Cycle classification
	// ------------------------------------------------------------
	assign needCycles = lockPrecisionBit ? LOCK_CYCLES_FINE : LOCK_CYCLES_COARSE;
	assign quietCycle = phaseErrorNs < LOCK_WINDOW_NS;
	assign loudCycle = phaseErrorNs > UNLOCK_LIMIT_NS;

	// Errors between the two limits restart the count but keep lock
	always_comb begin
		nxt_state = state_ff;
		nxt_quiet = quiet_ff;
		if (compareTick) begin
			nxt_quiet = quietCycle ? ((quiet_ff == 3'h7) ? quiet_ff : quiet_ff + 3'h1) : 3'h0;
			case (state_ff)
				LOCK_HUNT: begin
					if (quietCycle && (quiet_ff + 3'h1 >= needCycles)) begin
						nxt_state = LOCK_HELD;
					end
				end
				LOCK_HELD: begin
					if (loudCycle) begin
						nxt_state = LOCK_HUNT;
					end
				end
				default: begin
					nxt_state = LOCK_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= LOCK_HUNT;
			quiet_ff <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			quiet_ff <= nxt_quiet;
		end
	end

	assign lockIndicator = (state_ff == LOCK_HELD);

endmodule
`default_nettype wire

/* rtl/synth_serial_function_latch.sv */
// Serial programming front end and lock output of the synthesizer loop chip
`timescale 1ns/1ps
`default_nettype none

module synth_serial_function_latch
	import synth_serial_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic serialClock,
	input wire logic serialData,
	input wire logic loadStrobe,
	input wire logic compareTick,
	input wire logic [ERR_BITS-1:0] phaseErrorNs,
	input wire logic pumpUp,
	input wire logic pumpDown,
	output logic [FUNC_BITS-1:0] functionControlWord,
	output logic [REF_DIV_BITS-1:0] refDivider,
	output logic lockPrecisionBit,
	output logic [FB_BITS-1:0] feedbackWord,
	output logic counterHold,
	output logic internalResetPulse,
	output logic powerdownBitLow,
	output logic powerdownBitHigh,
	output logic multifunctionLockOut,
	output logic multifunctionLockOutEn
);

	// ------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ------------------------------------------------------------
	logic [2:0] pinSync;
	logic sclkPrev_ff;
	logic lePrev_ff;
	logic nxt_sclkPrev;
	logic nxt_lePrev;
	logic sclkRise;
	logic leRise;
	logic dataSync;

	// Link clock is slow enough for plain oversampling
	// Raw pins are never read past this point
	pin_sync #(
		.WIDTH(3)
	) pin_sync_inst (
		.clock(clock),
		.rst_n(rst_n),
		.pinIn({loadStrobe, serialData, serialClock}),
		.pinSync(pinSync)
	);

	// Data and clock share one synchroniser, so their skew is kept
	assign dataSync = pinSync[1];
	assign sclkRise = pinSync[0] & ~sclkPrev_ff;
	assign leRise = pinSync[2] & ~lePrev_ff;

	// Previous levels for edge detection
	always_comb begin
		nxt_sclkPrev = pinSync[0];
		nxt_lePrev = pinSync[2];
	end

	// Idle level of both pins is low, so no false edge after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev_ff <= 1'b0;
			lePrev_ff <= 1'b0;
		end else begin
			sclkPrev_ff <= nxt_sclkPrev;
			lePrev_ff <= nxt_lePrev;
		end
	end

	// ------------------------------------------------------------
	// Shift register
	// ------------------------------------------------------------
	// Holds the last word's worth of bits
	logic [WORD_BITS-1:0] shift_ff;
	logic [WORD_BITS-1:0] nxt_shift;

	// Bits enter at the bottom, so the first bit ends on top
	always_comb begin
		nxt_shift = shift_ff;
		if (sclkRise) begin
			nxt_shift = {shift_ff[WORD_BITS-2:0], dataSync};
		end
	end

	// Older bits fall off the top as new ones enter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_ff <= SHIFT_RESET;
		end else begin
			shift_ff <= nxt_shift;
		end
	end

	// ------------------------------------------------------------
	// Latch transfer
	// ------------------------------------------------------------
	// Latched words and the sequencing flags
	logic [1:0] destCode;
	logic [REF_BITS-1:0] wordPayload;
	logic [FUNC_BITS-1:0] payload;
	logic loadRef;
	logic loadFeedback;
	logic loadFunction;
	logic loadInit;
	logic [FUNC_BITS-1:0] func_ff;
	logic [FUNC_BITS-1:0] nxt_func;
	logic [REF_BITS-1:0] ref_ff;
	logic [REF_BITS-1:0] nxt_ref;
	logic [FB_BITS-1:0] fb_ff;
	logic [FB_BITS-1:0] nxt_fb;
	logic initPending_ff;
	logic nxt_initPending;
	logic resetPulse_ff;
	logic nxt_resetPulse;
	logic holdCount_ff;
	logic nxt_holdCount;

	// Control bits are the last two shifted
	assign destCode = {shift_ff[DEST_HI_POS], shift_ff[DEST_LO_POS]};
	assign wordPayload = shift_ff[WORD_BITS-1:PAYLOAD_POS];
	// Top word bit is spare in function words, so it is cut off here
	assign payload = wordPayload[FUNC_BITS-1:0];

	// ------------------------------------------------------------
	// Destination decode
	// ------------------------------------------------------------
	// One strobe per latch, only in the cycle of the load edge
	always_comb begin
		loadRef = 1'b0;
		loadFeedback = 1'b0;
		loadFunction = 1'b0;
		loadInit = 1'b0;
		if (leRise) begin
			case (destCode)
				DEST_REF: begin
					loadRef = 1'b1;
				end
				DEST_FEEDBACK: begin
					loadFeedback = 1'b1;
				end
				DEST_FUNCTION: begin
					loadFunction = 1'b1;
				end
				DEST_INIT: begin
					loadInit = 1'b1;
				end
				default: begin
					loadRef = 1'b0;
				end
			endcase
		end
	end

	// Transfer once per load pulse; a long high level does not repeat it
	always_comb begin
		nxt_func = func_ff;
		nxt_ref = ref_ff;
		nxt_fb = fb_ff;
		nxt_initPending = initPending_ff;
		nxt_resetPulse = 1'b0;
		if (loadRef) begin
			nxt_ref = wordPayload;
		end
		if (loadFeedback) begin
			nxt_fb = wordPayload;
			nxt_initPending = 1'b0;
		end
		// Both control codes write the one shared register
		if (loadFunction || loadInit) begin
			nxt_func = payload;
		end
		// Only the initialisation code adds the reset pulse and the hold
		if (loadInit) begin
			nxt_resetPulse = 1'b1;
			nxt_initPending = 1'b1;
		end
	end

	// Counters sit at load point from init load until feedback word lands
	always_comb begin
		nxt_holdCount = nxt_func[COUNTER_RESET_POS] | nxt_initPending;
	end

	// All latches clear to zero, so the pin is driven low after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			func_ff <= FUNC_RESET;
			ref_ff <= REF_RESET;
			fb_ff <= FB_RESET;
			initPending_ff <= 1'b0;
			resetPulse_ff <= 1'b0;
			holdCount_ff <= 1'b0;
		end else begin
			func_ff <= nxt_func;
			ref_ff <= nxt_ref;
			fb_ff <= nxt_fb;
			initPending_ff <= nxt_initPending;
			resetPulse_ff <= nxt_resetPulse;
			holdCount_ff <= nxt_holdCount;
		end
	end

	// ------------------------------------------------------------
	// Lock detection
	// ------------------------------------------------------------
	// Lock pin state
	logic digitalLock;
	logic [OUT_SEL_BITS-1:0] outSelect;
	logic lockOut_ff;
	logic nxt_lockOut;
	logic lockOutEn_ff;
	logic nxt_lockOutEn;
	logic pumpActive;

	// Precision follows the top bit of the last reference word
	digital_lock_detect digital_lock_detect_inst (
		.clock(clock),
		.rst_n(rst_n),
		.compareTick(compareTick),
		.phaseErrorNs(phaseErrorNs),
		.lockPrecisionBit(ref_ff[LOCK_PRECISION_POS]),
		.lockIndicator(digitalLock)
	);

	// Output function field and pump activity
	assign outSelect = func_ff[OUT_SEL_POS +: OUT_SEL_BITS];
	assign pumpActive = pumpUp | pumpDown;

	// Analog mode shows pump activity: short pulses when locked, long when not
	always_comb begin
		nxt_lockOut = 1'b0;
		nxt_lockOutEn = 1'b1;
		case (outSelect)
			OUT_SEL_DIGITAL_LOCK: begin
				nxt_lockOut = digitalLock;
				nxt_lockOutEn = 1'b1;
			end
			OUT_SEL_ANALOG_LOCK: begin
				nxt_lockOut = 1'b0;
				nxt_lockOutEn = pumpActive;
			end
			default: begin
				nxt_lockOut = 1'b0;
				nxt_lockOutEn = 1'b1;
			end
		endcase
	end

	// Register only, so the pin never glitches between modes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lockOut_ff <= 1'b0;
			lockOutEn_ff <= 1'b1;
		end else begin
			lockOut_ff <= nxt_lockOut;
			lockOutEn_ff <= nxt_lockOutEn;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ------------------------------------------------------------
	// Latched words
	assign functionControlWord = func_ff;
	assign refDivider = ref_ff[REF_DIV_BITS-1:0];
	assign lockPrecisionBit = ref_ff[LOCK_PRECISION_POS];
	assign feedbackWord = fb_ff;

	// Counter control and lock pin
	assign counterHold = holdCount_ff;
	assign internalResetPulse = resetPulse_ff;
	assign powerdownBitLow = func_ff[POWERDOWN_LO_POS];
	assign powerdownBitHigh = func_ff[POWERDOWN_HI_POS];
	assign multifunctionLockOut = lockOut_ff;
	assign multifunctionLockOutEn = lockOutEn_ff;

endmodule
`default_nettype wire

/* testbench/synth_serial_function_latch_properties.sv */
// Port-level checks of the synthesizer serial front end and lock output
`timescale 1ns/1ps
`default_nettype none
module synth_serial_function_latch_properties
	import synth_serial_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic serialClock,
	input wire logic serialData,
	input wire logic loadStrobe,
	input wire logic compareTick,
	input wire logic [ERR_BITS-1:0] phaseErrorNs,
	input wire logic pumpUp,
	input wire logic pumpDown,
	input wire logic [FUNC_BITS-1:0] functionControlWord,
	input wire logic [REF_DIV_BITS-1:0] refDivider,
	input wire logic lockPrecisionBit,
	input wire logic [FB_BITS-1:0] feedbackWord,
	input wire logic counterHold,
	input wire logic internalResetPulse,
	input wire logic powerdownBitLow,
	input wire logic powerdownBitHigh,
	input wire logic multifunctionLockOut,
	input wire logic multifunctionLockOutEn
);
	// ----------------
	// Mode decode
	// ----------------
	wire logic [2:0] outSel;
	wire logic digital;
	assign outSel = functionControlWord[OUT_SEL_POS +: OUT_SEL_BITS];
	assign digital = outSel == OUT_SEL_DIGITAL_LOCK;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Quiet comparator runs, back to back
	sequence quiet_coarse;
		(digital && !lockPrecisionBit && compareTick && phaseErrorNs < LOCK_WINDOW_NS)[*3];
	endsequence
	sequence quiet_fine;
		(digital && lockPrecisionBit && compareTick && phaseErrorNs < LOCK_WINDOW_NS)[*5];
	endsequence
	// ----------------
	// Assertions
	// ----------------
	a_lock_rise_coarse: assert property (quiet_coarse |-> ##2 multifunctionLockOut)
		else $error("lock not shown after three quiet ticks");
	a_lock_rise_fine: assert property (quiet_fine |-> ##2 multifunctionLockOut)
		else $error("lock not shown after five quiet ticks");
	a_lock_drop: assert property ((digital && compareTick && phaseErrorNs > UNLOCK_LIMIT_NS)
		|-> ##2 !multifunctionLockOut) else $error("lock kept after large error");
	a_analog_pulse: assert property ($stable(outSel) && outSel == OUT_SEL_ANALOG_LOCK
		|-> !multifunctionLockOut && multifunctionLockOutEn == $past(pumpUp || pumpDown))
		else $error("analog output not following pump activity");
	a_other_low: assert property ($stable(outSel) && !digital && outSel != OUT_SEL_ANALOG_LOCK
		|-> !multifunctionLockOut && multifunctionLockOutEn) else $error("unused mode not low");
	a_pulse_single: assert property (internalResetPulse |=> !internalResetPulse)
		else $error("reset pulse wider than one cycle");
	a_hold_on_init: assert property (internalResetPulse |-> ##[0:1] counterHold)
		else $error("counters not held after init load");
	a_hold_on_bit: assert property (functionControlWord[COUNTER_RESET_POS]
		|-> ##[0:1] counterHold) else $error("counter reset bit ignored");
	a_power_bits: assert property ($stable(functionControlWord) |->
		{powerdownBitHigh, powerdownBitLow} == {functionControlWord[POWERDOWN_HI_POS],
		functionControlWord[POWERDOWN_LO_POS]}) else $error("power-down outputs wrong");
	a_words_quiet: assert property ((!loadStrobe)[*8] |=> $stable(functionControlWord)
		&& $stable(refDivider) && $stable(feedbackWord)) else $error("word changed without load");
endmodule
`default_nettype wire

/* testbench/host_serial_model.sv */
// Host model driving the three-wire programming link
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
	output logic serialClock,
	output logic serialData,
	output logic loadStrobe
);
	// Link idles with clock stopped low
	initial begin
		serialClock = 1'b0;
		serialData = 1'b0;
		loadStrobe = 1'b0;
	end
	// Data changes only while clock is low, so it is settled long before the rise
	task automatic send_bit(input logic b);
		serialData = b;
		#62.5 serialClock = 1'b1;
		#62.5 serialClock = 1'b0;
	endtask
	// Optional stale bits, then the word MSB first, then one load pulse
	task automatic send_word(input logic [20:0] w, input logic [3:0] junk, input logic junkOn);
		if (junkOn)
			for (int i = 3; i >= 0; i--) send_bit(junk[i]);
		for (int i = 20; i >= 0; i--) send_bit(w[i]);
		#62.5 loadStrobe = 1'b1;
		serialData = ~w[0]; // Released line must not keep showing the last bit
		#80 loadStrobe = 1'b0;
		#80;
	endtask
endmodule
`default_nettype wire

/* testbench/synth_serial_function_latch_test.sv */
// Self-checking bench of the synthesizer serial front end
`timescale 1ns/1ps
`default_nettype none
module synth_serial_function_latch_test
	import synth_serial_pkg::*;
;
	typedef logic [52:0] snap_type;
	logic clock, rst_n, compareTick, pumpUp, pumpDown, lockPrecisionBit, counterHold;
	logic internalResetPulse, powerdownBitLow, powerdownBitHigh, lockOut, lockOutEn;
	logic [ERR_BITS-1:0] phaseErrorNs;
	logic [FUNC_BITS-1:0] functionControlWord, expFunc;
	logic [REF_DIV_BITS-1:0] refDivider, expRef;
	logic [FB_BITS-1:0] feedbackWord, expFb;
	logic expPrec, initPending;
	logic [31:0] r;
	wire logic serialClock, serialData, loadStrobe;
	snap_type expQ[$];
	snap_type curSnap, prevSnap;
	int n_fail = 0, checks_done = 0, cycles = 0, seed = 33148;

	synth_serial_function_latch synth_serial_function_latch_inst (.clock(clock), .rst_n(rst_n),
		.serialClock(serialClock), .serialData(serialData), .loadStrobe(loadStrobe),
		.compareTick(compareTick), .phaseErrorNs(phaseErrorNs), .pumpUp(pumpUp),
		.pumpDown(pumpDown), .functionControlWord(functionControlWord), .refDivider(refDivider),
		.lockPrecisionBit(lockPrecisionBit), .feedbackWord(feedbackWord),
		.counterHold(counterHold), .internalResetPulse(internalResetPulse),
		.powerdownBitLow(powerdownBitLow), .powerdownBitHigh(powerdownBitHigh),
		.multifunctionLockOut(lockOut), .multifunctionLockOutEn(lockOutEn));
	host_serial_model host_serial_model_inst (.serialClock(serialClock),
		.serialData(serialData), .loadStrobe(loadStrobe));

	always #5 clock = ~clock;

	// ----------------
	// Checking and report
	// ----------------
	task automatic check_val(input logic [63:0] seen, input logic [63:0] expVal);
		checks_done++;
		if (seen !== expVal) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expVal);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Each word change or reset pulse retires the oldest note; a hang is cut off
	always @(negedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end else begin
			curSnap = {functionControlWord, lockPrecisionBit, refDivider, feedbackWord,
				internalResetPulse};
			if (rst_n && (curSnap[52:1] !== prevSnap[52:1] || internalResetPulse))
				check_val(curSnap, (expQ.size() > 0) ? expQ.pop_front() : ~curSnap);
			prevSnap = curSnap;
		end
	end

	// ----------------
	// Stimulus
	// ----------------
	// Host keeps polarity 1 and pump, fast-settle, timeout and test bits 0
	function automatic logic [18:0] func_word(input logic [2:0] sel, input logic [2:0] ctl);
		return {1'b0, ctl[2], 12'h001, sel, ctl[1:0]};
	endfunction
	// Note the expected latch state, send the word, then check the counter hold
	task automatic load_word(input logic [1:0] dest, input logic [18:0] pay, input logic junkOn);
		logic [31:0] j;
		j = $random(seed);
		case (dest)
			DEST_REF: {expPrec, expRef} = {pay[18], pay[13:0]};
			DEST_FEEDBACK: {expFb, initPending} = {pay, 1'b0};
			default: expFunc = pay[17:0];
		endcase
		initPending = initPending | (dest == DEST_INIT);
		expQ.push_back({expFunc, expPrec, expRef, expFb, dest == DEST_INIT});
		host_serial_model_inst.send_word({pay, dest}, j[3:0], junkOn);
		repeat (12) @(negedge clock);
		check_val(counterHold, initPending | expFunc[COUNTER_RESET_POS]);
	endtask
	// Back-to-back comparator ticks with errors in lo..lo+span-1
	task automatic ticks(input int n, input int lo, input int span);
		for (int i = 0; i < n; i++) begin
			@(negedge clock);
			compareTick = 1'b1;
			phaseErrorNs = 8'(lo + ($unsigned($random(seed)) % span));
		end
		@(negedge clock);
		compareTick = 1'b0;
		repeat (2) @(negedge clock);
	endtask

	initial begin
		{clock, rst_n, compareTick, pumpUp, pumpDown, phaseErrorNs} = '0;
		{expFunc, expRef, expPrec, expFb, initPending} = '0;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		check_val({functionControlWord, refDivider, feedbackWord, counterHold}, 64'h0);
		r = $random(seed);
		load_word(DEST_INIT, func_word(OUT_SEL_DIGITAL_LOCK, {2'b00, r[0]}), 1'b0);
		load_word(DEST_REF, {5'h00, r[13:0]}, 1'b1);
		load_word(DEST_FEEDBACK, r[31:13], 1'b0);
		ticks(3, 0, 15);
		check_val(lockOut, 1'b1);
		ticks(1, 15, 16);
		check_val(lockOut, 1'b1);
		ticks(1, 31, 225);
		check_val(lockOut, 1'b0);
		load_word(DEST_REF, {5'h10, r[27:14]}, 1'b0);
		ticks(4, 0, 15);
		check_val(lockOut, 1'b0);
		ticks(1, 31, 225);
		ticks(5, 0, 15);
		check_val(lockOut, 1'b1);
		// Every output code, one of them through the initialisation latch
		for (int c = 0; c < 8; c++) begin
			r = $random(seed);
			load_word((c == 3) ? DEST_INIT : DEST_FUNCTION, func_word(3'(c), r[2:0]), 1'b0);
			check_val({lockOut, lockOutEn}, {c == 1, c != 5});
			check_val({powerdownBitHigh, powerdownBitLow}, r[2:1]);
			for (int i = 0; i < 8 && c == 5; i++) begin
				@(negedge clock);
				{pumpUp, pumpDown} = {r[i + 3], r[i + 12]};
				@(negedge clock);
				check_val({lockOut, lockOutEn}, {1'b0, r[i + 3] | r[i + 12]});
			end
			{pumpUp, pumpDown} = 2'b00;
		end
		load_word(DEST_FEEDBACK, r[30:12], 1'b0);
		check_val(expQ.size(), 0);
		final_report();
	end
endmodule

bind synth_serial_function_latch synth_serial_function_latch_properties
	synth_serial_function_latch_properties_inst (.clock(clock), .rst_n(rst_n),
	.serialClock(serialClock), .serialData(serialData), .loadStrobe(loadStrobe),
	.compareTick(compareTick), .phaseErrorNs(phaseErrorNs), .pumpUp(pumpUp),
	.pumpDown(pumpDown), .functionControlWord(functionControlWord), .refDivider(refDivider),
	.lockPrecisionBit(lockPrecisionBit), .feedbackWord(feedbackWord),
	.counterHold(counterHold), .internalResetPulse(internalResetPulse),
	.powerdownBitLow(powerdownBitLow), .powerdownBitHigh(powerdownBitHigh),
	.multifunctionLockOut(multifunctionLockOut),
	.multifunctionLockOutEn(multifunctionLockOutEn));
`default_nettype wire
